//--- isq_pkg.sv
// package of constants for the two-wire master sequencer
package isq_pkg;
   // register indexes on the plain register port
   localparam logic [2:0] ADDR_CMD = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_RELOAD = 3'h2;
   localparam logic [2:0] ADDR_BUF = 3'h3;
   // command register field positions
   localparam int CMD_START = 0;
   localparam int CMD_RESTART = 1;
   localparam int CMD_RECEIVE = 3;
   localparam int CMD_ACKSEQ = 4;
   localparam int CMD_ACKDATA = 5;
   localparam int CMD_ACK_STATUS_BIT = 6;
   // status register field positions
   localparam int ST_BF = 0;
   localparam int ST_START_SEEN = 3;
   localparam int ST_IRQ = 4;
   localparam int ST_BCOL = 5;
   localparam int ST_WRITE_COLLISION_FLAG = 6;
   localparam int ST_OVF = 7;
   // reset values
   localparam logic [6:0] RELOAD_RST = 7'h09;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // baud counter steps per system clock (two per instruction cycle)
   localparam int BAUD_STEP = 2;
   // sequencer states
   typedef enum logic [12:0] {
      ST_IDLE = 13'h0001,
      ST_S_WAIT = 13'h0002,
      ST_S_HOLD = 13'h0004,
      ST_R_LOW = 13'h0008,
      ST_R_SDA = 13'h0010,
      ST_R_SCLW = 13'h0020,
      ST_R_HIGH = 13'h0040,
      ST_R_SDALO = 13'h0080,
      ST_B_LOW = 13'h0100,
      ST_B_SCLW = 13'h0200,
      ST_B_HIGH = 13'h0400,
      ST_A_LOW = 13'h0800,
      ST_A_HIGH = 13'h1000
   } isq_state_t;
endpackage

//--- isq_sequencer.sv
// two-wire master bus-condition and byte sequencer
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module isq_sequencer (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // bus pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a change counts once stages two and three agree
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   logic scl_q;
   logic sda_q;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         if (scl_s_q[1] == scl_s_q[2]) begin
            scl_q <= scl_s_q[2];
         end
         if (sda_s_q[1] == sda_s_q[2]) begin
            sda_q <= sda_s_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state, registers
   isq_pkg::isq_state_t state_q;
   logic [7:0] baud_q;
   logic [6:0] reload_q;
   logic [7:0] buf_q;
   logic [7:0] shreg_q;
   logic [3:0] bit_q;
   logic rx_q;
   logic start_cmd_q;
   logic restart_cmd_q;
   logic receive_cmd_q;
   logic ack_sequence_cmd_q;
   logic ack_data_bit_q;
   logic ack_status_bit_q;
   logic bf_q;
   logic start_seen_q;
   logic irq_q;
   logic bcol_q;
   logic write_collision_flag_q;
   logic ovf_q;
   logic scl_drive_q;
   logic sda_drive_q;
   logic [7:0] rdata_q;

   // the counter may step past zero in one clock; clamp so it lands on zero
   function automatic logic [7:0] baud_step(input logic [7:0] v);
      if (v <= 8'(isq_pkg::BAUD_STEP)) begin
         baud_step = 8'h00;
      end else begin
         baud_step = v - 8'(isq_pkg::BAUD_STEP);
      end
   endfunction

   logic cond_busy;
   logic wr_cmd;
   logic wr_buf;
   logic rd_buf;
   logic tmo;
   assign cond_busy = (state_q != isq_pkg::ST_IDLE);
   assign wr_cmd = reg_wr_i && (reg_addr_i == isq_pkg::ADDR_CMD);
   assign wr_buf = reg_wr_i && (reg_addr_i == isq_pkg::ADDR_BUF);
   assign rd_buf = reg_rd_i && (reg_addr_i == isq_pkg::ADDR_BUF);
   assign tmo = (baud_q == 8'h00);

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= isq_pkg::ST_IDLE;
         baud_q <= 8'h00;
         bit_q <= 4'h0;
         rx_q <= 1'b0;
         shreg_q <= isq_pkg::BYTE_RST;
         buf_q <= isq_pkg::BYTE_RST;
         start_cmd_q <= 1'b0;
         restart_cmd_q <= 1'b0;
         receive_cmd_q <= 1'b0;
         ack_sequence_cmd_q <= 1'b0;
         ack_data_bit_q <= 1'b0;
         ack_status_bit_q <= 1'b0;
         reload_q <= isq_pkg::RELOAD_RST;
         bf_q <= 1'b0;
         start_seen_q <= 1'b0;
         irq_q <= 1'b0;
         bcol_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         ovf_q <= 1'b0;
         scl_drive_q <= 1'b0;
         sda_drive_q <= 1'b0;
      end else begin
         if (!tmo) begin
            baud_q <= baud_step(baud_q);
         end
         // software writes; hardware sets below override clears (set wins)
         if (reg_wr_i && reg_addr_i == isq_pkg::ADDR_RELOAD) begin
            reload_q <= reg_wdata_i[6:0];
         end
         if (reg_wr_i && reg_addr_i == isq_pkg::ADDR_STATUS) begin
            irq_q <= reg_wdata_i[isq_pkg::ST_IRQ];
            bcol_q <= reg_wdata_i[isq_pkg::ST_BCOL];
            write_collision_flag_q <= reg_wdata_i[isq_pkg::ST_WRITE_COLLISION_FLAG];
            ovf_q <= reg_wdata_i[isq_pkg::ST_OVF];
         end
         if (wr_cmd) begin
            ack_data_bit_q <= reg_wdata_i[isq_pkg::CMD_ACKDATA];
         end
         // once idle after a transmit the flag is already clear, so idle reads are harmless
         if (rd_buf && (rx_q || !cond_busy)) begin
            bf_q <= 1'b0;
         end
         // buffer writes: refused while anything is in progress
         if (wr_buf) begin
            if (cond_busy) begin
               write_collision_flag_q <= 1'b1;
            end else begin
               buf_q <= reg_wdata_i;
               shreg_q <= reg_wdata_i;
               bf_q <= 1'b1;
               rx_q <= 1'b0;
               // first bit goes out now, while the clock is still held low
               sda_drive_q <= !reg_wdata_i[7];
               bit_q <= 4'h0;
               baud_q <= {1'b0, reload_q};
               scl_drive_q <= 1'b1;
               state_q <= isq_pkg::ST_B_LOW;
            end
         end else if (wr_cmd && !cond_busy) begin
            // commands accepted only when idle, events are not queued
            if (reg_wdata_i[isq_pkg::CMD_START]) begin
               start_cmd_q <= 1'b1;
               if (!sda_q || !scl_q) begin
                  bcol_q <= 1'b1;
                  start_cmd_q <= 1'b0;
               end else begin
                  baud_q <= {1'b0, reload_q};
                  state_q <= isq_pkg::ST_S_WAIT;
               end
            end else if (reg_wdata_i[isq_pkg::CMD_RESTART]) begin
               restart_cmd_q <= 1'b1;
               scl_drive_q <= 1'b1;
               state_q <= isq_pkg::ST_R_LOW;
            end else if (reg_wdata_i[isq_pkg::CMD_RECEIVE]) begin
               receive_cmd_q <= 1'b1;
               rx_q <= 1'b1;
               bit_q <= 4'h0;
               sda_drive_q <= 1'b0;
               baud_q <= {1'b0, reload_q};
               state_q <= isq_pkg::ST_B_LOW;
            end else if (reg_wdata_i[isq_pkg::CMD_ACKSEQ]) begin
               ack_sequence_cmd_q <= 1'b1;
               scl_drive_q <= 1'b1;
               sda_drive_q <= !reg_wdata_i[isq_pkg::CMD_ACKDATA];
               baud_q <= {1'b0, reload_q};
               state_q <= isq_pkg::ST_A_LOW;
            end
         end else begin
            case (state_q)
               isq_pkg::ST_IDLE: begin
               end
               isq_pkg::ST_S_WAIT: begin
                  if (!scl_q) begin
                     bcol_q <= 1'b1;
                     start_cmd_q <= 1'b0;
                     state_q <= isq_pkg::ST_IDLE;
                  end else if (!sda_q || tmo) begin
                     sda_drive_q <= 1'b1;
                     start_seen_q <= 1'b1;
                     baud_q <= {1'b0, reload_q};
                     state_q <= isq_pkg::ST_S_HOLD;
                  end
               end
               isq_pkg::ST_S_HOLD: begin
                  if (tmo) begin
                     start_cmd_q <= 1'b0;
                     irq_q <= 1'b1;
                     scl_drive_q <= 1'b1;
                     state_q <= isq_pkg::ST_IDLE;
                  end
               end
               isq_pkg::ST_R_LOW: begin
                  if (!scl_q) begin
                     baud_q <= {2'b00, reload_q[5:0]};
                     sda_drive_q <= 1'b0;
                     state_q <= isq_pkg::ST_R_SDA;
                  end
               end
               isq_pkg::ST_R_SDA: begin
                  if (tmo && sda_q) begin
                     scl_drive_q <= 1'b0;
                     state_q <= isq_pkg::ST_R_SCLW;
                  end
               end
               isq_pkg::ST_R_SCLW: begin
                  if (scl_q) begin
                     if (!sda_q) begin
                        bcol_q <= 1'b1;
                        restart_cmd_q <= 1'b0;
                        state_q <= isq_pkg::ST_IDLE;
                     end else begin
                        baud_q <= {1'b0, reload_q};
                        state_q <= isq_pkg::ST_R_HIGH;
                     end
                  end
               end
               isq_pkg::ST_R_HIGH: begin
                  if (!scl_q) begin
                     bcol_q <= 1'b1;
                     restart_cmd_q <= 1'b0;
                     state_q <= isq_pkg::ST_IDLE;
                  end else if (tmo) begin
                     sda_drive_q <= 1'b1;
                     start_seen_q <= 1'b1;
                     baud_q <= {1'b0, reload_q};
                     state_q <= isq_pkg::ST_R_SDALO;
                  end
               end
               isq_pkg::ST_R_SDALO: begin
                  if (tmo) begin
                     restart_cmd_q <= 1'b0;
                     irq_q <= 1'b1;
                     scl_drive_q <= 1'b1;
                     state_q <= isq_pkg::ST_IDLE;
                  end
               end
               isq_pkg::ST_B_LOW: begin
                  if (tmo) begin
                     scl_drive_q <= 1'b0;
                     state_q <= isq_pkg::ST_B_SCLW;
                  end
               end
               isq_pkg::ST_B_SCLW: begin
                  if (scl_q) begin
                     baud_q <= {1'b0, reload_q};
                     state_q <= isq_pkg::ST_B_HIGH;
                  end
               end
               isq_pkg::ST_B_HIGH: begin
                  if (tmo) begin
                     // falling edge of clock bit_q+1
                     scl_drive_q <= 1'b1;
                     bit_q <= bit_q + 4'h1;
                     baud_q <= {1'b0, reload_q};
                     state_q <= isq_pkg::ST_B_LOW;
                     if (rx_q) begin
                        shreg_q <= {shreg_q[6:0], sda_q};
                        if (bit_q == 4'h7) begin
                           buf_q <= {shreg_q[6:0], sda_q};
                           bf_q <= 1'b1;
                           ovf_q <= ovf_q | bf_q;
                           irq_q <= 1'b1;
                           baud_q <= 8'h00;
                           receive_cmd_q <= 1'b0;
                           rx_q <= 1'b0;
                           state_q <= isq_pkg::ST_IDLE;
                        end
                     end else if (bit_q == 4'h7) begin
                        bf_q <= 1'b0;
                        sda_drive_q <= 1'b0;
                     end else if (bit_q == 4'h8) begin
                        ack_status_bit_q <= sda_q;
                        irq_q <= 1'b1;
                        baud_q <= 8'h00;
                        state_q <= isq_pkg::ST_IDLE;
                     end else begin
                        sda_drive_q <= !shreg_q[3'h6 - bit_q[2:0]];
                     end
                  end
               end
               isq_pkg::ST_A_LOW: begin
                  if (tmo) begin
                     scl_drive_q <= 1'b0;
                     state_q <= isq_pkg::ST_A_HIGH;
                     baud_q <= 8'h00;
                  end
               end
               isq_pkg::ST_A_HIGH: begin
                  if (scl_q && baud_q == 8'h00 && !ack_sequence_cmd_q) begin
                     state_q <= isq_pkg::ST_IDLE;
                  end else if (scl_q && tmo && rx_q) begin
                     scl_drive_q <= 1'b1;
                     ack_sequence_cmd_q <= 1'b0;
                     rx_q <= 1'b0;
                     state_q <= isq_pkg::ST_IDLE;
                  end else if (scl_q && !rx_q) begin
                     baud_q <= {1'b0, reload_q};
                     rx_q <= 1'b1;
                  end
               end
               default: begin
                  state_q <= isq_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port: data stand one cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            isq_pkg::ADDR_CMD: rdata_q <= {1'b0, ack_status_bit_q, ack_data_bit_q,
               ack_sequence_cmd_q, receive_cmd_q, 1'b0, restart_cmd_q, start_cmd_q};
            isq_pkg::ADDR_STATUS: rdata_q <= {ovf_q, write_collision_flag_q, bcol_q, irq_q,
               start_seen_q, 2'b00, bf_q};
            isq_pkg::ADDR_RELOAD: rdata_q <= {1'b0, reload_q};
            isq_pkg::ADDR_BUF: rdata_q <= buf_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign scl_o = 1'b0;
   assign scl_oe_o = scl_drive_q;
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_drive_q;
endmodule

//--- isq_sequencer_checker.sv
// port checker for the two-wire master sequencer
`timescale 1ns/1ps
module isq_sequencer_checker (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // bus pins
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic [6:0] reload_q;
   logic cmd_wr;
   assign cmd_wr = reg_wr_i && reg_addr_i == isq_pkg::ADDR_CMD;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reload_q <= isq_pkg::RELOAD_RST;
      end else if (reg_wr_i && reg_addr_i == isq_pkg::ADDR_RELOAD) begin
         reload_q <= reg_wdata_i[6:0];
      end
   end
   ////////////////////////////////////////////////////////////////
   // four clocks per baud period assume a reload of at least 8
   sequence s_start_req;
      cmd_wr && reg_wdata_i[isq_pkg::CMD_START] && !scl_oe_o && !sda_oe_o && scl_i && sda_i;
   endsequence
   sequence s_start_wait;
      !scl_oe_o throughout (!sda_oe_o[*3] ##[1:80] sda_oe_o);
   endsequence
   a_start_sda:
      assert property (s_start_req |=> s_start_wait) else $error("start edge missing");
   a_start_scl:
      assert property ($rose(sda_oe_o) && !scl_oe_o |=> !scl_oe_o[*3] ##[1:70] scl_oe_o)
      else $error("clock not pulled low after start");
   a_scl_low_period:
      assert property ($rose(scl_oe_o) |-> scl_oe_o[*4]) else $error("clock low too short");
   a_scl_high_period:
      assert property ($fell(scl_oe_o) |-> !scl_oe_o[*4]) else $error("clock high too short");
   a_sda_change_low:
      assert property ($fell(sda_oe_o) |-> scl_oe_o) else $error("data released with clock high");
   a_reload_read:
      assert property (reg_rd_i && reg_addr_i == isq_pkg::ADDR_RELOAD |=>
         reg_rdata_o[6:0] == reload_q) else $error("reload read wrong");
   a_ack_drive:
      assert property (cmd_wr && reg_wdata_i[5:0] == 6'h10 && scl_oe_o |-> ##[1:4]
         (sda_oe_o && scl_oe_o)) else $error("ack low not driven");
   a_rcv_quiet:
      assert property (cmd_wr && reg_wdata_i[4:0] == 5'h08 && scl_oe_o && !sda_oe_o |=>
         !sda_oe_o[*8]) else $error("data driven while receiving");
   a_unmapped_zero:
      assert property (reg_rd_i && reg_addr_i > 3'h3 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_open_drain:
      assert property (!scl_o && !sda_o) else $error("pin driven high");
endmodule

bind isq_sequencer isq_sequencer_checker isq_sequencer_checker_inst (.ref_clk_i(ref_clk_i),
   .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

//--- isq_sequencer_tb.sv
// self-checking testbench of the two-wire master sequencer
`timescale 1ns/1ps
module isq_sequencer_tb;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [2:0] reg_addr_i = 3'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic scl_oe_o, sda_oe_o, slv_scl_oe, slv_sda_oe;
   logic hold_sda = 1'b0, rx_mode = 1'b0, nack = 1'b0, clr = 1'b0;
   logic [7:0] tx_byte = 8'h00, stretch = 8'h00, st, d, b;
   logic [8:0] mon = 9'h000;
   integer seed = 30, fail_count = 0, checks_done = 0, cycles = 0, i;
   wire scl_w = !(scl_oe_o | slv_scl_oe);
   wire sda_w = !(sda_oe_o | slv_sda_oe | hold_sda);
   initial begin
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   isq_sequencer isq_sequencer_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_w), .scl_o(),
      .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o));
   isq_slave_model isq_slave_model_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .scl_i(scl_w), .rx_mode_i(rx_mode), .nack_i(nack), .clr_i(clr), .tx_byte_i(tx_byte),
      .stretch_i(stretch), .scl_oe_o(slv_scl_oe), .sda_oe_o(slv_sda_oe));
   // bits on the wire as seen at each clock rise
   always @(posedge scl_w) mon <= {mon[7:0], sda_w};
   ////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         final_report;
      end
   end
   function automatic logic [7:0] stat(input logic bf, input logic ir, input logic wc,
      input logic ov);
      stat = 8'h00;
      stat[isq_pkg::ST_BF] = bf;
      stat[isq_pkg::ST_IRQ] = ir;
      stat[isq_pkg::ST_WRITE_COLLISION_FLAG] = wc;
      stat[isq_pkg::ST_OVF] = ov;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
      rd(a, d);
      chk(d & m, exp);
   endtask
   // polls a register bit under a bounded count
   task automatic wait_st(input logic [2:0] a, input int p, input logic v);
      st = ~{8{v}};
      for (int n = 0; n < 500 && st[p] !== v; n++) rd(a, st);
      chk({7'h00, st[p]}, {7'h00, v});
   endtask
   task automatic slv_clr;
      @(posedge ref_clk_i);
      clr <= 1'b1;
      @(posedge ref_clk_i);
      clr <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rchk(isq_pkg::ADDR_RELOAD, 8'h7f, {1'b0, isq_pkg::RELOAD_RST});
      rchk(3'h6, 8'hff, 8'h00);
      // reload 8 gives five clocks a baud period, a 1500 ns bus clock with the synchroniser wait
      wr(isq_pkg::ADDR_RELOAD, 8'h08);
      rchk(isq_pkg::ADDR_RELOAD, 8'h7f, 8'h08);
      hold_sda <= 1'b1;
      // let the pin synchroniser settle before the command
      repeat (6) @(posedge ref_clk_i);
      wr(isq_pkg::ADDR_CMD, 8'h01);
      wait_st(isq_pkg::ADDR_STATUS, isq_pkg::ST_BCOL, 1'b1);
      rchk(isq_pkg::ADDR_CMD, 8'h01, 8'h00);
      hold_sda <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      wr(isq_pkg::ADDR_STATUS, 8'h00);
      $display("test collision done");
      wr(isq_pkg::ADDR_CMD, 8'h01);
      wr(isq_pkg::ADDR_BUF, 8'h5a);
      wr(isq_pkg::ADDR_CMD, 8'h02);
      wait_st(isq_pkg::ADDR_STATUS, isq_pkg::ST_IRQ, 1'b1);
      chk(st & stat(1, 1, 1, 1), stat(0, 1, 1, 0));
      chk({7'h00, st[isq_pkg::ST_START_SEEN]}, 8'h01);
      rchk(isq_pkg::ADDR_CMD, 8'h03, 8'h00);
      rchk(isq_pkg::ADDR_BUF, 8'hff, isq_pkg::BYTE_RST);
      wr(isq_pkg::ADDR_STATUS, 8'h00);
      $display("test start done");
      for (i = 0; i < 6; i++) begin
         b = 8'($random(seed));
         nack <= i[0];
         stretch <= (i > 3) ? 8'h0a : 8'h00;
         slv_clr;
         wr(isq_pkg::ADDR_BUF, b);
         wr(isq_pkg::ADDR_BUF, ~b);
         if (i == 1) wr(isq_pkg::ADDR_CMD, 8'h02);
         rchk(isq_pkg::ADDR_STATUS, stat(1, 1, 1, 0), stat(1, 0, 1, 0));
         wait_st(isq_pkg::ADDR_STATUS, isq_pkg::ST_IRQ, 1'b1);
         chk(st & stat(1, 0, 1, 0), stat(0, 0, 1, 0));
         chk(mon[8:1], b);
         rchk(isq_pkg::ADDR_CMD, 8'h42, {1'b0, i[0], 6'h00});
         rchk(isq_pkg::ADDR_BUF, 8'hff, b);
         wr(isq_pkg::ADDR_STATUS, 8'h00);
      end
      $display("test transmit done");
      rx_mode <= 1'b1;
      for (i = 0; i < 3; i++) begin
         b = 8'($random(seed));
         tx_byte <= b;
         slv_clr;
         wr(isq_pkg::ADDR_CMD, 8'h08);
         wr(isq_pkg::ADDR_BUF, 8'hc3);
         wait_st(isq_pkg::ADDR_STATUS, isq_pkg::ST_IRQ, 1'b1);
         chk(st & stat(1, 0, 1, 1), stat(1, 0, 1, i == 2));
         rchk(isq_pkg::ADDR_CMD, 8'h08, 8'h00);
         if (i == 0) begin
            rchk(isq_pkg::ADDR_BUF, 8'hff, b);
            rchk(isq_pkg::ADDR_STATUS, 8'h01, 8'h00);
         end
         wr(isq_pkg::ADDR_STATUS, 8'h00);
         wr(isq_pkg::ADDR_CMD, {2'b00, i[0], 5'h10});
         wait_st(isq_pkg::ADDR_CMD, isq_pkg::CMD_ACKSEQ, 1'b0);
         chk({7'h00, mon[0]}, {7'h00, i[0]});
      end
      $display("test receive done");
      wr(isq_pkg::ADDR_CMD, 8'h02);
      wr(isq_pkg::ADDR_BUF, 8'h3c);
      wait_st(isq_pkg::ADDR_STATUS, isq_pkg::ST_IRQ, 1'b1);
      chk(st & stat(0, 0, 1, 0), stat(0, 0, 1, 0));
      chk({7'h00, st[isq_pkg::ST_START_SEEN]}, 8'h01);
      rchk(isq_pkg::ADDR_CMD, 8'h02, 8'h00);
      chk({6'h00, scl_w, sda_w}, 8'h00);
      rchk(isq_pkg::ADDR_BUF, 8'hff, b);
      $display("test restart done");
      final_report;
   end
endmodule

//--- isq_slave_model.sv
// behavioural bus slave: acknowledges, sends bytes, stretches the clock
`timescale 1ns/1ps
module isq_slave_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // resolved clock line
   input wire logic scl_i,
   // behaviour controls
   input wire logic rx_mode_i,
   input wire logic nack_i,
   input wire logic clr_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic [7:0] stretch_i,
   // pulls, high = line low
   output logic scl_oe_o,
   output logic sda_oe_o
);
   logic [1:0] scl_q;
   logic [3:0] cnt_q;
   logic [7:0] hold_q;
   // falls are seen two clocks late, well inside a five clock low period
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_q <= 2'b11;
         cnt_q <= 4'hf;
         hold_q <= 8'h00;
      end else begin
         scl_q <= {scl_q[0], scl_i};
         if (clr_i) begin
            cnt_q <= 4'h0;
         end else if (scl_q == 2'b10 && cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
         end
         if (scl_q == 2'b10) begin
            hold_q <= stretch_i;
         end else if (hold_q != 8'h00) begin
            hold_q <= hold_q - 8'h01;
         end
      end
   end
   // a released line floats to the pull-up level
   assign scl_oe_o = hold_q != 8'h00;
   assign sda_oe_o = rx_mode_i ? (cnt_q < 4'h8 && !tx_byte_i[3'h7 - cnt_q[2:0]])
      : (cnt_q == 4'h8 && !nack_i);
endmodule
